// [logic/hjg_cfg.svh]
// register map, field positions, reset values and codes of the axis block
`ifndef HJG_CFG_SVH
`define HJG_CFG_SVH
`define HJG_A_CTRL   6'h00
`define HJG_A_METH   6'h04
`define HJG_A_ZOFF   6'h08
`define HJG_A_FSEL   6'h0c
`define HJG_A_SLOW   6'h10
`define HJG_A_FAST   6'h14
`define HJG_A_HSPD   6'h18
`define HJG_A_GNUM   6'h1c
`define HJG_A_GDEN   6'h20
`define HJG_A_SFAC   6'h24
`define HJG_A_TFAC   6'h28
`define HJG_A_STAT   6'h2c
`define HJG_A_POS    6'h30
`define HJG_A_GPOS   6'h34
`define HJG_B_START  0
`define HJG_B_JBUS   1
`define HJG_B_BJP    2
`define HJG_B_BJN    3
`define HJG_FN_JOGP  4'h7
`define HJG_FN_JOGN  4'h8
`define HJG_M_M33    6'h21
`define HJG_M_M35    6'h23
`define HJG_R_GEAR   16'h0001
`define HJG_R_FAC    16'h0100
`define HJG_R_SPD    16'h0000
`define HJG_F_A      2'h0
`define HJG_F_B      2'h1
`define HJG_F_Z      2'h2
`define HJG_F_N      2'h3
`define HJG_OKAY     2'h0
`define HJG_SLVERR   2'h2
`endif

// [logic/hjg_pkg.sv]
// types of the homing, jog and gearing block
`default_nettype none
package hjg_pkg;
  typedef enum logic [2:0] {
    HS_IDLE, HS_SEEK, HS_FALL, HS_RISE, HS_ZERO
  } hjg_hst_t;
  typedef struct packed {
    logic [9:0]         s1;
    logic [9:0]         s2;
    logic [9:0]         s3;
    logic [9:0]         flt;
    logic               aw_ok;
    logic               w_ok;
    logic [5:0]         awa;
    logic [31:0]        wd;
    logic [3:0]         ws;
    logic               bv;
    logic [1:0]         br;
    logic               rv;
    logic [31:0]        rd;
    logic [1:0]         rr;
    logic               jbus;
    logic               bjp;
    logic               bjn;
    logic [5:0]         meth;
    logic [31:0]        zoff;
    logic [15:0]        fsel;
    logic [15:0]        slow;
    logic [15:0]        fast;
    logic [15:0]        hspd;
    logic [15:0]        num;
    logic [15:0]        den;
    logic [15:0]        sfac;
    logic [15:0]        tfac;
    hjg_hst_t           st;
    logic [1:0]         fam;
    logic               dir;
    logic               rev;
    logic               nozp;
    logic               done;
    logic               err;
    logic [1:0]         first;
    logic [31:0]        pos;
    logic [31:0]        gpos;
    logic signed [39:0] rem;
    logic [15:0]        spre;
    logic [15:0]        tpre;
    logic               en;
    logic               mdir;
    logic [15:0]        spd;
  } hjg_st_t;
endpackage
`default_nettype wire

// [logic/hjg_top.sv]
// homing, jog and electronic gearing logic of one servo axis
// What this block does
// R01: method 11 reverses at cam, zero at first pulse after cam fall.
// R02: method 12 takes pulse under cam, else reverse and zero after rise.
// R03: method 13 mirrors 12 in the other direction of start.
// R04: method 14 passes over cam, zero at first pulse after fall.
// R05: methods 15 and 16 are undefined and start no motion.
// R06: methods 27 to 30 run the sequence of the method sixteen lower.
// R07: methods 27 to 30 take the cam edge itself, ignoring zero pulse, except 28 and 29 started on cam, which zero at once.
// R08: methods 31 and 32 are undefined and start no motion.
// R09: method 33 moves left, zero at first zero pulse.
// R10: method 34 moves right, zero at first zero pulse.
// R11: method 35 moves nowhere; actual position becomes reference.
// R12: jog source is bus bits or terminals; speeds in user units.
// R13: slow and fast jog speed in each direction.
// R14: input function 7 jogs positive, 8 jogs negative, while active.
// R15: fast jog only while both jog requests are active.
// R16: negative first then positive gives fast jog negative.
// R17: positive first then negative gives fast jog positive.
// R18: gear ratio is a fraction; remainder kept, no rounding drift.
// R19: speed pre-control is scaled by the speed factor.
// R20: torque pre-control is scaled by the torque factor.
// R21: tracking-error monitoring is off during a homing run.
// R22: zero event loads offset, stops motion, sets homing done.
// R23: undefined method flags a configuration error, no motion.
`include "hjg_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module hjg_top (
  // clock and reset
  input  wire logic        CLOCK_IN,
  input  wire logic        SRST_IN,
  // axi4-lite slave
  input  wire logic [5:0]  AWADDR_IN,
  input  wire logic        AWVALID_IN,
  output logic             AWREADY_OUT,
  input  wire logic [31:0] WDATA_IN,
  input  wire logic [3:0]  WSTRB_IN,
  input  wire logic        WVALID_IN,
  output logic             WREADY_OUT,
  output logic [1:0]       BRESP_OUT,
  output logic             BVALID_OUT,
  input  wire logic        BREADY_IN,
  input  wire logic [5:0]  ARADDR_IN,
  input  wire logic        ARVALID_IN,
  output logic             ARREADY_OUT,
  output logic [31:0]      RDATA_OUT,
  output logic [1:0]       RRESP_OUT,
  output logic             RVALID_OUT,
  input  wire logic        RREADY_IN,
  // switch, cam and encoder pins
  input  wire logic        CAM_IN,
  input  wire logic        LIM_POS_IN,
  input  wire logic        LIM_NEG_IN,
  input  wire logic        ZERO_PULSE_IN,
  input  wire logic        ENC_STEP_IN,
  input  wire logic        ENC_UP_IN,
  input  wire logic [3:0]  DIG_IN,
  // master reference, same clock
  input  wire logic [15:0] MASTER_DELTA_IN,
  input  wire logic [15:0] MASTER_VEL_IN,
  input  wire logic [15:0] MASTER_ACC_IN,
  // motion controller
  output logic             MOTION_EN_OUT,
  output logic             MOTION_DIR_OUT,
  output logic [15:0]      SPEED_OUT,
  output logic             HOMING_ACTIVE_OUT,
  output logic             HOMING_DONE_OUT,
  output logic             TRK_MON_EN_OUT,
  output logic [31:0]      ACT_POS_OUT,
  output logic [31:0]      GEAR_POS_OUT,
  output logic [15:0]      SPEED_PRE_OUT,
  output logic [15:0]      TORQUE_PRE_OUT
);
  import hjg_pkg::*;

  hjg_st_t s_q;
  hjg_st_t s_d;
  logic [9:0] pins;
  logic [3:0] jp_t;
  logic [3:0] jn_t;

  assign pins = {DIG_IN, ENC_UP_IN, ENC_STEP_IN, ZERO_PULSE_IN,
                 LIM_NEG_IN, LIM_POS_IN, CAM_IN};

  // each terminal input may carry a jog function
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_fsel
      assign jp_t[gi] = s_q.flt[6+gi]
        && s_q.fsel[gi*4 +: 4] == `HJG_FN_JOGP; // [R14]
      assign jn_t[gi] = s_q.flt[6+gi]
        && s_q.fsel[gi*4 +: 4] == `HJG_FN_JOGN; // [R14]
    end
  endgenerate

  function automatic logic [31:0] hjg_merge(
    input logic [31:0] o,
    input logic [31:0] d,
    input logic [3:0]  b
  );
    logic [31:0] r;
    r = o;
    for (int k = 0; k < 4; k++)
      if (b[k])
        r[k*8 +: 8] = d[k*8 +: 8];
    return r;
  endfunction

  // returns {ok, family, start dir, reverse at cam, no zero pulse}
  function automatic logic [5:0] hjg_dec(input logic [5:0] m);
    logic [5:0] b;
    logic       nz;
    nz = (m >= 6'h1b) && (m <= 6'h1e); // [R06] [R07]
    b = nz ? m - 6'h10 : m; // [R06]
    case (b)
      6'h0b:   hjg_dec = {1'b1, `HJG_F_A, 1'b1, 1'b1, nz}; // [R01]
      6'h0c:   hjg_dec = {1'b1, `HJG_F_B, 1'b1, 1'b0, nz}; // [R02]
      6'h0d:   hjg_dec = {1'b1, `HJG_F_B, 1'b0, 1'b0, nz}; // [R03]
      6'h0e:   hjg_dec = {1'b1, `HJG_F_A, 1'b0, 1'b0, nz}; // [R04]
      6'h21:   hjg_dec = {1'b1, `HJG_F_Z, 1'b0, 1'b0, 1'b0}; // [R09]
      6'h22:   hjg_dec = {1'b1, `HJG_F_Z, 1'b1, 1'b0, 1'b0}; // [R10]
      6'h23:   hjg_dec = {1'b1, `HJG_F_N, 1'b0, 1'b0, 1'b0}; // [R11]
      default: hjg_dec = 6'h00; // [R05] [R08]
    endcase
  endfunction

  always_comb
  begin
    logic [9:0]         fn;
    logic               cam_r;
    logic               cam_f;
    logic               zp_r;
    logic               stp_r;
    logic               start;
    logic               zero_ev;
    logic [5:0]         dc;
    logic               jp;
    logic               jn;
    logic signed [39:0] acc;
    logic signed [32:0] pv;
    logic signed [32:0] pt;
    s_d = s_q;
    start = 1'b0;
    zero_ev = 1'b0;
    fn = 10'h000;
    cam_r = 1'b0;
    cam_f = 1'b0;
    zp_r = 1'b0;
    stp_r = 1'b0;
    dc = 6'h00;
    jp = 1'b0;
    jn = 1'b0;
    acc = 40'sh0;
    pv = 33'sh0;
    pt = 33'sh0;
    // a change counts once the second and third stage agree
    s_d.s1 = pins;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    for (int k = 0; k < 10; k++)
      fn[k] = (s_q.s2[k] == s_q.s3[k]) ? s_q.s2[k] : s_q.flt[k];
    s_d.flt = fn;
    cam_r = fn[0] & ~s_q.flt[0];
    cam_f = ~fn[0] & s_q.flt[0];
    zp_r = fn[3] & ~s_q.flt[3];
    stp_r = fn[4] & ~s_q.flt[4];

    // bus write: address and data taken in either order
    if (AWVALID_IN && AWREADY_OUT)
    begin
      s_d.aw_ok = 1'b1;
      s_d.awa = {AWADDR_IN[5:2], 2'b00};
    end
    if (WVALID_IN && WREADY_OUT)
    begin
      s_d.w_ok = 1'b1;
      s_d.wd = WDATA_IN;
      s_d.ws = WSTRB_IN;
    end
    if (s_q.aw_ok && s_q.w_ok && !s_q.bv)
    begin
      s_d.aw_ok = 1'b0;
      s_d.w_ok = 1'b0;
      s_d.bv = 1'b1;
      s_d.br = `HJG_OKAY;
      case (s_q.awa)
        `HJG_A_CTRL:
        begin
          if (s_q.ws[0])
          begin
            start = s_q.wd[`HJG_B_START];
            s_d.jbus = s_q.wd[`HJG_B_JBUS]; // [R12]
            s_d.bjp = s_q.wd[`HJG_B_BJP];
            s_d.bjn = s_q.wd[`HJG_B_BJN];
          end
        end
        `HJG_A_METH:
          if (s_q.ws[0])
            s_d.meth = s_q.wd[5:0];
        `HJG_A_ZOFF: s_d.zoff = hjg_merge(s_q.zoff, s_q.wd, s_q.ws);
        `HJG_A_FSEL:
          s_d.fsel = 16'(hjg_merge({16'h0, s_q.fsel}, s_q.wd, s_q.ws));
        `HJG_A_SLOW:
          s_d.slow = 16'(hjg_merge({16'h0, s_q.slow}, s_q.wd, s_q.ws));
        `HJG_A_FAST:
          s_d.fast = 16'(hjg_merge({16'h0, s_q.fast}, s_q.wd, s_q.ws));
        `HJG_A_HSPD:
          s_d.hspd = 16'(hjg_merge({16'h0, s_q.hspd}, s_q.wd, s_q.ws));
        `HJG_A_GNUM:
          s_d.num = 16'(hjg_merge({16'h0, s_q.num}, s_q.wd, s_q.ws));
        `HJG_A_GDEN:
          s_d.den = 16'(hjg_merge({16'h0, s_q.den}, s_q.wd, s_q.ws));
        `HJG_A_SFAC:
          s_d.sfac = 16'(hjg_merge({16'h0, s_q.sfac}, s_q.wd, s_q.ws));
        `HJG_A_TFAC:
          s_d.tfac = 16'(hjg_merge({16'h0, s_q.tfac}, s_q.wd, s_q.ws));
        `HJG_A_STAT, `HJG_A_POS, `HJG_A_GPOS: ;
        default: s_d.br = `HJG_SLVERR;
      endcase
    end
    if (s_q.bv && BREADY_IN)
      s_d.bv = 1'b0;

    // bus read
    if (ARVALID_IN && ARREADY_OUT)
    begin
      s_d.rv = 1'b1;
      s_d.rr = `HJG_OKAY;
      case ({ARADDR_IN[5:2], 2'b00})
        `HJG_A_CTRL: s_d.rd = {28'h0, s_q.bjn, s_q.bjp, s_q.jbus, 1'b0};
        `HJG_A_METH: s_d.rd = {26'h0, s_q.meth};
        `HJG_A_ZOFF: s_d.rd = s_q.zoff;
        `HJG_A_FSEL: s_d.rd = {16'h0, s_q.fsel};
        `HJG_A_SLOW: s_d.rd = {16'h0, s_q.slow};
        `HJG_A_FAST: s_d.rd = {16'h0, s_q.fast};
        `HJG_A_HSPD: s_d.rd = {16'h0, s_q.hspd};
        `HJG_A_GNUM: s_d.rd = {16'h0, s_q.num};
        `HJG_A_GDEN: s_d.rd = {16'h0, s_q.den};
        `HJG_A_SFAC: s_d.rd = {16'h0, s_q.sfac};
        `HJG_A_TFAC: s_d.rd = {16'h0, s_q.tfac};
        `HJG_A_STAT: s_d.rd = {26'h0, s_q.first, s_q.dir,
                               s_q.err, s_q.done, s_q.st != HS_IDLE};
        `HJG_A_POS:  s_d.rd = s_q.pos;
        `HJG_A_GPOS: s_d.rd = s_q.gpos;
        default:
        begin
          s_d.rd = 32'h0;
          s_d.rr = `HJG_SLVERR;
        end
      endcase
    end
    if (s_q.rv && RREADY_IN)
      s_d.rv = 1'b0;

    // encoder count; a zero event below overrides it
    if (stp_r)
      s_d.pos = fn[5] ? s_q.pos + 32'h1 : s_q.pos - 32'h1;

    // homing sequencer
    dc = hjg_dec(s_q.meth);
    case (s_q.st)
      HS_IDLE:
        if (start)
        begin
          s_d.done = 1'b0;
          s_d.err = !dc[5]; // [R23] [R05] [R08]
          s_d.fam = dc[4:3];
          s_d.dir = dc[2];
          s_d.rev = dc[1];
          s_d.nozp = dc[0];
          if (!dc[5])
            s_d.st = HS_IDLE; // [R23]
          else if (dc[4:3] == `HJG_F_N)
            zero_ev = 1'b1; // [R11]
          else if (dc[4:3] == `HJG_F_Z)
            s_d.st = HS_ZERO; // [R09] [R10]
          else if (!s_q.flt[0])
            s_d.st = HS_SEEK;
          else if (dc[4:3] == `HJG_F_B)
            s_d.st = HS_ZERO; // [R02] [R03]
          else
          begin
            s_d.dir = !dc[2]; // [R01] [R04]
            s_d.st = HS_FALL;
          end
        end
      HS_SEEK:
      begin
        // an end switch in the travel direction means the cam lies behind
        // only the switch edge reverses; its level would flip every cycle
        if ((s_q.dir && fn[1] && !s_q.flt[1])
            || (!s_q.dir && fn[2] && !s_q.flt[2]))
          s_d.dir = !s_q.dir;
        if (cam_r)
        begin
          s_d.st = HS_FALL;
          if (s_q.rev)
            s_d.dir = !s_q.dir; // [R01]
        end
      end
      HS_FALL:
        if (cam_f)
        begin
          if (s_q.fam == `HJG_F_B)
          begin
            s_d.dir = !s_q.dir; // [R02] [R03]
            s_d.st = HS_RISE;
          end
          else if (s_q.nozp)
            zero_ev = 1'b1; // [R07]
          else
            s_d.st = HS_ZERO; // [R01] [R04]
        end
      HS_RISE:
        if (cam_r)
        begin
          if (s_q.nozp)
            zero_ev = 1'b1; // [R07]
          else
            s_d.st = HS_ZERO; // [R02] [R03]
        end
      HS_ZERO:
        if (zp_r || s_q.nozp)
          zero_ev = 1'b1;
      default: s_d.st = HS_IDLE;
    endcase
    if (zero_ev)
    begin
      s_d.pos = s_q.zoff; // [R22]
      s_d.done = 1'b1; // [R22]
      s_d.st = HS_IDLE; // [R22]
    end

    // jog: remember which request came first
    jp = s_q.jbus ? s_q.bjp : |jp_t; // [R12] [R14]
    jn = s_q.jbus ? s_q.bjn : |jn_t; // [R12] [R14]
    if (!jp && !jn)
      s_d.first = 2'h0;
    else if (s_q.first == 2'h0)
      s_d.first = jp ? 2'h1 : 2'h2;
    else if (!(jp && jn))
      s_d.first = jp ? 2'h1 : 2'h2;

    // motion request
    if (s_d.st != HS_IDLE)
    begin
      s_d.en = 1'b1;
      s_d.mdir = s_d.dir;
      s_d.spd = s_q.hspd;
    end
    else if (jp && jn)
    begin
      s_d.en = 1'b1; // [R15]
      s_d.spd = s_q.fast; // [R13] [R15]
      s_d.mdir = s_q.first != 2'h2; // [R16] [R17]
    end
    else
    begin
      s_d.en = jp || jn; // [R14]
      s_d.spd = s_q.slow; // [R13]
      s_d.mdir = jp; // [R14]
    end

    // gearing: remainder carried so the ratio never drifts
    acc = s_q.rem + 40'(signed'(MASTER_DELTA_IN)
                      * signed'({1'b0, s_q.num})); // [R18]
    if (s_q.den != 16'h0)
    begin
      if (acc >= signed'({24'h0, s_q.den}))
      begin
        acc = acc - signed'({24'h0, s_q.den}); // [R18]
        s_d.gpos = s_q.gpos + 32'h1;
      end
      else if (acc < 0)
      begin
        acc = acc + signed'({24'h0, s_q.den}); // [R18]
        s_d.gpos = s_q.gpos - 32'h1;
      end
      s_d.rem = acc;
    end
    pv = signed'(MASTER_VEL_IN) * signed'({1'b0, s_q.sfac});
    pt = signed'(MASTER_ACC_IN) * signed'({1'b0, s_q.tfac});
    s_d.spre = pv[23:8]; // [R19]
    s_d.tpre = pt[23:8]; // [R20]
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      s_q <= '0;
      s_q.st <= HS_IDLE;
      s_q.num <= `HJG_R_GEAR;
      s_q.den <= `HJG_R_GEAR;
      s_q.sfac <= `HJG_R_FAC;
      s_q.tfac <= `HJG_R_FAC;
      s_q.hspd <= `HJG_R_SPD;
    end
    else
      s_q <= s_d;
  end

  assign AWREADY_OUT = !s_q.aw_ok && !s_q.bv;
  assign WREADY_OUT = !s_q.w_ok && !s_q.bv;
  assign BVALID_OUT = s_q.bv;
  assign BRESP_OUT = s_q.br;
  assign ARREADY_OUT = !s_q.rv;
  assign RVALID_OUT = s_q.rv;
  assign RDATA_OUT = s_q.rd;
  assign RRESP_OUT = s_q.rr;
  assign MOTION_EN_OUT = s_q.en;
  assign MOTION_DIR_OUT = s_q.mdir;
  assign SPEED_OUT = s_q.spd;
  assign HOMING_ACTIVE_OUT = s_q.st != HS_IDLE;
  assign HOMING_DONE_OUT = s_q.done;
  assign TRK_MON_EN_OUT = s_q.st == HS_IDLE; // [R21]
  assign ACT_POS_OUT = s_q.pos;
  assign GEAR_POS_OUT = s_q.gpos;
  assign SPEED_PRE_OUT = s_q.spre;
  assign TORQUE_PRE_OUT = s_q.tpre;

  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (SRST_IN);

  a_trk_mon_off: assert property ( // [R21]
    s_q.st != HS_IDLE |=> !TRK_MON_EN_OUT || s_q.done)
    else $error("tracking monitor on during homing");
  a_undef_meth: assert property ( // [R23]
    s_q.st == HS_IDLE && s_d.st == HS_IDLE && s_d.err && !s_q.err
    |=> !MOTION_EN_OUT || !HOMING_ACTIVE_OUT)
    else $error("undefined method started homing");
  a_zero_load: assert property ( // [R22]
    s_q.st == HS_ZERO && !s_q.nozp && s_q.s2[3] && s_q.s3[3]
    && !s_q.flt[3] |=> s_q.st == HS_IDLE && s_q.done
    && s_q.pos == $past(s_q.zoff))
    else $error("zero pulse did not load offset");
  a_zero_done: assert property ( // [R22]
    $rose(s_q.done) |-> s_q.pos == $past(s_q.zoff)
    && s_q.st == HS_IDLE)
    else $error("zero event did not load offset");
  a_m35_now: assert property ( // [R11]
    s_q.st == HS_IDLE && s_q.meth == `HJG_M_M35 && s_d.done && !s_q.done
    |=> s_q.st == HS_IDLE ##1 !HOMING_ACTIVE_OUT)
    else $error("method 35 moved");
  a_m33_left: assert property ( // [R09]
    s_q.st == HS_ZERO && s_q.meth == `HJG_M_M33 |=> !MOTION_DIR_OUT)
    else $error("method 33 not moving left");
  a_fast_jog: assert property ( // [R15]
    s_q.st == HS_IDLE && s_d.st == HS_IDLE && !s_q.jbus
    && |jp_t && |jn_t |=> SPEED_OUT == $past(s_q.fast) && MOTION_EN_OUT)
    else $error("fast jog speed not applied");
  a_jog_first: assert property ( // [R16]
    s_q.st == HS_IDLE && s_d.st == HS_IDLE && s_q.first == 2'h2
    && s_d.first == 2'h2 && s_q.jbus && s_q.bjp && s_q.bjn
    |=> !MOTION_DIR_OUT)
    else $error("fast jog left taken wrong way");
  a_gear_hold: assert property ( // [R18]
    s_q.den == 16'h0 |=> $stable(s_q.gpos) && $stable(s_q.rem))
    else $error("gear moved with zero denominator");
endmodule // hjg_top
`default_nettype wire

// [testbench/hjg_axis_model.sv]
// behavioural axis: motor, encoder, reference cam and end switches
`timescale 1ns/1ps
`default_nettype none
module hjg_axis_model (
  // clock and model reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // motion controller request and zero mark enable
  input  wire logic en_in,
  input  wire logic dir_in,
  input  wire logic zp_en_in,
  // sensor pins
  output logic      cam_out,
  output logic      lim_pos_out,
  output logic      lim_neg_out,
  output logic      zero_out,
  output logic      step_out,
  output logic      up_out
);
  int   pos_q = 5;
  int   div_q = 0;
  logic up_q  = 1'b1;
  // one position every 8 clocks keeps each pin level past the sync filter
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pos_q <= 5;
      div_q <= 0;
    end
    else if (en_in)
    begin
      div_q <= (div_q + 1) % 8;
      if (div_q == 0)
        up_q <= dir_in;
      if (div_q == 7)
        pos_q <= dir_in ? pos_q + 1 : pos_q - 1;
    end
  end
  // direction settles before the step edge, as a quadrature decoder gives
  assign up_out      = up_q;
  assign step_out    = en_in && (div_q >= 4);
  assign cam_out     = (pos_q >= 20) && (pos_q <= 30);
  assign zero_out    = zp_en_in && (pos_q % 16 == 0);
  assign lim_pos_out = pos_q >= 60;
  assign lim_neg_out = pos_q <= -60;
endmodule // hjg_axis_model
`default_nettype wire

// [testbench/tb.sv]
// self-checking bench of the homing, jog and gearing block
`include "hjg_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  import hjg_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [5:0]  awaddr = 6'h00;
  logic [5:0]  araddr = 6'h00;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata, rd, apos, gpos;
  logic        cam, limp, limn, zp, step, up, men, mdir, hact, hdone, trk;
  logic        ax_rst = 1'b1;
  logic        zp_en = 1'b1;
  logic [3:0]  dig = 4'h0;
  logic [15:0] mdel = 16'h0;
  logic [15:0] mvel = 16'h0;
  logic [15:0] macc = 16'h0;
  logic [15:0] spd, spre, tpre;
  int          n_errors = 0;
  int          total_checks = 0;

  hjg_top dut (.CLOCK_IN(clk), .SRST_IN(srst), .AWADDR_IN(awaddr),
    .AWVALID_IN(awvalid), .AWREADY_OUT(awready), .WDATA_IN(wdata),
    .WSTRB_IN(wstrb), .WVALID_IN(wvalid), .WREADY_OUT(wready),
    .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
    .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready),
    .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid),
    .RREADY_IN(rready), .CAM_IN(cam), .LIM_POS_IN(limp), .LIM_NEG_IN(limn),
    .ZERO_PULSE_IN(zp), .ENC_STEP_IN(step), .ENC_UP_IN(up), .DIG_IN(dig),
    .MASTER_DELTA_IN(mdel), .MASTER_VEL_IN(mvel), .MASTER_ACC_IN(macc),
    .MOTION_EN_OUT(men), .MOTION_DIR_OUT(mdir), .SPEED_OUT(spd),
    .HOMING_ACTIVE_OUT(hact), .HOMING_DONE_OUT(hdone),
    .TRK_MON_EN_OUT(trk), .ACT_POS_OUT(apos), .GEAR_POS_OUT(gpos),
    .SPEED_PRE_OUT(spre), .TORQUE_PRE_OUT(tpre));

  hjg_axis_model axis (.clk_in(clk), .rst_in(ax_rst), .en_in(men),
    .dir_in(mdir), .zp_en_in(zp_en), .cam_out(cam), .lim_pos_out(limp),
    .lim_neg_out(limn), .zero_out(zp), .step_out(step), .up_out(up));

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic hang;
    chk(32'h0, 32'h1);
    final_report();
  endtask

  // handshakes are judged on the values that stand up to the rising edge
  task automatic axi_wr(input logic [5:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    int   i;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 200; i++)
    begin
      @(negedge clk);
      ah = awvalid & awready;
      wh = wvalid & wready;
      bh = bvalid;
      rs = bresp;
      @(posedge clk);
      if (ah)
        awvalid <= 1'b0;
      if (wh)
        wvalid <= 1'b0;
      if (bh)
        break;
    end
    bready <= 1'b0;
    if (i == 200)
      hang();
  endtask

  task automatic axi_rd(input logic [5:0] a);
    logic ah, rh;
    int   i;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 200; i++)
    begin
      @(negedge clk);
      ah = arvalid & arready;
      rh = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge clk);
      if (ah)
        arvalid <= 1'b0;
      if (rh)
        break;
    end
    rready <= 1'b0;
    if (i == 200)
      hang();
  endtask

  task automatic sc_regs;
    chk(trk, 1'b1);
    axi_rd(`HJG_A_GNUM);
    chk(rd, 32'h1);
    axi_rd(`HJG_A_SFAC);
    chk(rd, 32'h100);
    axi_rd(`HJG_A_TFAC);
    chk(rd, 32'h100);
    axi_rd(`HJG_A_STAT);
    chk(rd, 32'h0);
    axi_rd(6'h38);
    chk(rs, `HJG_SLVERR);
    chk(rd, 32'h0);
    axi_wr(6'h3c, 32'h5);
    chk(rs, `HJG_SLVERR);
    axi_wr(`HJG_A_POS, 32'h1234);
    chk(rs, `HJG_OKAY);
    axi_rd(`HJG_A_POS);
    chk(rd, 32'h0);
  endtask

  task automatic sc_undef;
    logic [5:0] um [4] = '{6'd15, 6'd16, 6'd31, 6'd32};
    foreach (um[k])
    begin
      axi_wr(`HJG_A_METH, {26'h0, um[k]});
      axi_wr(`HJG_A_CTRL, 32'h1);
      repeat (3) @(posedge clk);
      #1;
      chk({men, hact}, 2'b00);
      axi_rd(`HJG_A_STAT);
      chk(rd[2:0], 3'b100);
    end
  endtask

  task automatic sc_m35;
    axi_wr(`HJG_A_METH, {26'h0, `HJG_M_M35});
    axi_wr(`HJG_A_CTRL, 32'h1);
    @(posedge clk);
    #1;
    chk({hdone, hact, men}, 3'b100);
  endtask

  task automatic home(input logic [5:0] m, input logic dr, input logic ze,
                      input logic [31:0] off);
    int i;
    @(posedge clk);
    ax_rst <= 1'b1;
    zp_en <= ze;
    @(posedge clk);
    ax_rst <= 1'b0;
    axi_wr(`HJG_A_METH, {26'h0, m});
    axi_wr(`HJG_A_ZOFF, off);
    axi_wr(`HJG_A_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    #1;
    chk({hact, trk, men, mdir}, {3'b101, dr});
    chk(spd, 16'h0040);
    for (i = 0; i < 4000; i++)
    begin
      @(posedge clk);
      #1;
      if (hdone === 1'b1)
        break;
    end
    if (i == 4000)
      hang();
    chk(apos, off);
    @(posedge clk);
    #1;
    chk({men, hact, trk}, 3'b001);
  endtask

  task automatic sc_homing;
    axi_wr(`HJG_A_HSPD, 32'h40);
    home(6'd34, 1'b1, 1'b1, 32'h100);
    home(6'd33, 1'b0, 1'b1, 32'h200);
    home(6'd11, 1'b1, 1'b1, 32'h300);
    home(6'd12, 1'b1, 1'b1, 32'h500);
    home(6'd14, 1'b0, 1'b1, 32'h600);
    home(6'd27, 1'b1, 1'b0, 32'h400);
  endtask

  task automatic jog(input logic bus, input logic [3:0] d, input logic e,
                     input logic dr, input logic [15:0] s);
    if (bus)
      axi_wr(`HJG_A_CTRL, {28'h0, d});
    @(posedge clk);
    if (!bus)
      dig <= d;
    repeat (8) @(posedge clk);
    #1;
    chk(men, e);
    if (e)
      chk({mdir, spd}, {dr, s});
  endtask

  task automatic sc_jog;
    axi_wr(`HJG_A_FSEL, {24'h0, `HJG_FN_JOGN, `HJG_FN_JOGP});
    axi_wr(`HJG_A_SLOW, 32'h10);
    axi_wr(`HJG_A_FAST, 32'h100);
    jog(1'b0, 4'h1, 1'b1, 1'b1, 16'h10);
    jog(1'b0, 4'h3, 1'b1, 1'b1, 16'h100);
    jog(1'b0, 4'h0, 1'b0, 1'b0, 16'h0);
    jog(1'b0, 4'h2, 1'b1, 1'b0, 16'h10);
    jog(1'b0, 4'h3, 1'b1, 1'b0, 16'h100);
    jog(1'b0, 4'h0, 1'b0, 1'b0, 16'h0);
    jog(1'b1, 4'h6, 1'b1, 1'b1, 16'h10);
    jog(1'b1, 4'ha, 1'b1, 1'b0, 16'h10);
    jog(1'b1, 4'he, 1'b1, 1'b0, 16'h100);
    jog(1'b1, 4'h2, 1'b0, 1'b0, 16'h0);
  endtask

  task automatic sc_gear;
    axi_wr(`HJG_A_GNUM, 32'h3);
    axi_wr(`HJG_A_GDEN, 32'h4);
    axi_wr(`HJG_A_SFAC, 32'h200);
    axi_wr(`HJG_A_TFAC, 32'h80);
    @(posedge clk);
    mvel <= 16'h0100;
    macc <= 16'h0040;
    mdel <= 16'h0001;
    // 12 master steps at 3/4 leave fractions on the way but none at the end
    repeat (12) @(posedge clk);
    mdel <= 16'h0000;
    repeat (6) @(posedge clk);
    #1;
    chk(gpos, 32'h9);
    chk(spre, 16'h0200);
    chk(tpre, 16'h0020);
    axi_rd(`HJG_A_GPOS);
    chk(rd, 32'h9);
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    ax_rst <= 1'b0;
    sc_regs();
    sc_undef();
    sc_m35();
    sc_homing();
    sc_jog();
    sc_gear();
    final_report();
  end
endmodule // tb
`default_nettype wire
